// >>> hdl/rtcnt_periodic_counter.sv
// periodic real-time counter with AXI4-Lite register access
//
// Operation
// - one 8-bit up-counter compared against an 8-bit software modulo value
// - match flag in status bit 7 sets on the prescaler pulse that finds the counter at the modulo value
// - writing one clears flag and request; zero leaves it; reset clears it
// - source select bits 6:5: 00 low-power 1 kHz, 01 external, 1x internal
// - write changing source select clears prescaler and counter
// - interrupt request follows match flag while enable bit 4 is set
// - write changing divider select bits 3:0 clears prescaler and counter
// - reset clears source select, interrupt enable and divider select
// - source bit 0 low: off, 2^3, 2^5..2^10, 1, 2, 4, 10, 16, 100, 500, 1000
// - source bit 0 high: off, 2^10..2^16, then 1000 up to 200000
// - counting continues in wait mode; enabled match request wakes processor
// - counting continues in shallow stop, and in deep stop on the low-power source only; enabled match request wakes processor
// - low-power source works in both stop modes; others only shallow stop
// - with no running source there is no match event
// - debug mode freezes all counting
// - after debug, counting resumes from frozen value unless reconfigured
// - count register is read only; writes ignored
// - on match counter wraps to zero; flag sets on that step
// - modulo zero sets flag on every prescaler output pulse
// - modulo write clears prescaler and counter; reset sets modulo to zero
module rtcnt_periodic_counter
   import rtcnt_pkg::*;
#(
   parameter int ADDR_W = 4                      // AXI address width
)
(
   input  wire logic              clock,                 // 50 MHz system clock
   input  wire logic              rst_b,                 // synchronous reset, active low
   input  wire logic [ADDR_W-1:0] s_axil_awaddr,         // write address
   input  wire logic              s_axil_awvalid,        // write address valid
   output logic                   s_axil_awready,        // write address ready
   input  wire logic [31:0]       s_axil_wdata,          // write data
   input  wire logic [3:0]        s_axil_wstrb,          // write byte strobes
   input  wire logic              s_axil_wvalid,         // write data valid
   output logic                   s_axil_wready,         // write data ready
   output logic [1:0]             s_axil_bresp,          // write response
   output logic                   s_axil_bvalid,         // write response valid
   input  wire logic              s_axil_bready,         // write response ready
   input  wire logic [ADDR_W-1:0] s_axil_araddr,         // read address
   input  wire logic              s_axil_arvalid,        // read address valid
   output logic                   s_axil_arready,        // read address ready
   output logic [31:0]            s_axil_rdata,          // read data
   output logic [1:0]             s_axil_rresp,          // read response
   output logic                   s_axil_rvalid,         // read data valid
   input  wire logic              s_axil_rready,         // read data ready
   input  wire logic              low_power_1khz_osc,    // 1 kHz low-power oscillator
   input  wire logic              external_ref_clock,    // external reference clock
   input  wire logic              internal_32khz_clock,  // internal 32 kHz clock
   input  wire logic              deep_stop,             // processor in deeper stop mode
   input  wire logic              debug_active,          // processor in active debug mode
   output logic                   match_irq              // interrupt / wakeup request
);

   `include "rtcnt_cfg.svh"

   // ----------------------------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------------------------
   if (ADDR_W < 4)
   begin : g_bad_addr
      $error("ADDR_W must be at least 4");
   end

   // ----------------------------------------------------------------------------
   // address decode, shared by read and write channels
   // ----------------------------------------------------------------------------
   function automatic rtcnt_sel_t decode(input logic [ADDR_W-1:0] addr);
      rtcnt_sel_t s;
      s = RTCNT_SEL_NONE;
      if (addr[ADDR_W-1:2] == (ADDR_W-2)'(`RTCNT_OFS_STATUS_CONTROL >> 2))
         s = RTCNT_SEL_STATUS;
      else if (addr[ADDR_W-1:2] == (ADDR_W-2)'(`RTCNT_OFS_COUNT_VALUE >> 2))
         s = RTCNT_SEL_COUNT;
      else if (addr[ADDR_W-1:2] == (ADDR_W-2)'(`RTCNT_OFS_MODULO_LIMIT >> 2))
         s = RTCNT_SEL_MODULO;
      return s;
   endfunction

   // ----------------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------------
   localparam rtcnt_core_state_t RESET_STATE = '{
      aw_held    : 1'b0,
      aw_sel     : RTCNT_SEL_NONE,
      w_held     : 1'b0,
      w_data     : 8'h00,
      w_lane0    : 1'b0,
      bvalid     : 1'b0,
      bresp      : `RTCNT_RESP_OKAY,
      rvalid     : 1'b0,
      rdata      : 32'h0000_0000,
      rresp      : `RTCNT_RESP_OKAY,
      match_flag : 1'b0,
      ctrl       : '{source_select    : `RTCNT_RST_SOURCE,
                     match_irq_enable : 1'b0,
                     divider_select   : `RTCNT_RST_DIVIDER},
      modulo     : `RTCNT_RST_MODULO,
      count      : `RTCNT_RST_COUNT,
      irq        : 1'b0
   };

   rtcnt_core_state_t st_reg;
   rtcnt_core_state_t st_next;

   rtcnt_src_t  src_raw;
   rtcnt_src_t  src_rise;
   logic        sel_edge;
   logic        presc_tick;
   logic        presc_clear;
   logic        flag_clear;
   rtcnt_ctrl_t ctrl_wr;
   rtcnt_sel_t  ar_sel;

   // ----------------------------------------------------------------------------
   // source synchronisation and selection
   // ----------------------------------------------------------------------------
   assign src_raw = '{internal_32khz_clock : internal_32khz_clock,
                      external_ref_clock   : external_ref_clock,
                      low_power_1khz_osc   : low_power_1khz_osc};

   rtcnt_src_sync u_sync (
      .clock    (clock),
      .rst_b    (rst_b),
      .src_in   (src_raw),
      .src_rise (src_rise)
   );

   // external and internal sources stop in deep stop; no edge, no event
   always_comb
   begin
      if (st_reg.ctrl.source_select[1])
         sel_edge = src_rise.internal_32khz_clock & ~deep_stop;
      else if (st_reg.ctrl.source_select[0])
         sel_edge = src_rise.external_ref_clock & ~deep_stop;
      else
         sel_edge = src_rise.low_power_1khz_osc;
   end

   rtcnt_prescaler u_presc (
      .clock   (clock),
      .rst_b   (rst_b),
      .src_edge(sel_edge),
      .bank    (st_reg.ctrl.source_select[0]),
      .div_sel (st_reg.ctrl.divider_select),
      .clear   (presc_clear),
      .freeze  (debug_active),
      .tick    (presc_tick)
   );

   // ----------------------------------------------------------------------------
   // bus handshakes
   // ----------------------------------------------------------------------------
   assign s_axil_awready = ~st_reg.aw_held;
   assign s_axil_wready  = ~st_reg.w_held;
   assign s_axil_arready = ~st_reg.rvalid;
   assign ar_sel         = decode(s_axil_araddr);

   // ----------------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------------
   always_comb
   begin
      st_next     = st_reg;
      presc_clear = 1'b0;
      flag_clear  = 1'b0;
      ctrl_wr     = st_reg.ctrl;

      // write address and data are taken independently
      if (s_axil_awvalid && !st_reg.aw_held)
      begin
         st_next.aw_held = 1'b1;
         st_next.aw_sel  = decode(s_axil_awaddr);
      end
      if (s_axil_wvalid && !st_reg.w_held)
      begin
         st_next.w_held  = 1'b1;
         st_next.w_data  = s_axil_wdata[7:0];
         st_next.w_lane0 = s_axil_wstrb[0];
      end
      if (st_reg.bvalid && s_axil_bready)
         st_next.bvalid = 1'b0;

      // perform the write once both halves are held
      if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid)
      begin
         st_next.aw_held = 1'b0;
         st_next.w_held  = 1'b0;
         st_next.bvalid  = 1'b1;
         st_next.bresp   = `RTCNT_RESP_OKAY;
         unique case (st_reg.aw_sel)
            RTCNT_SEL_STATUS:
               if (st_reg.w_lane0)
               begin
                  flag_clear = st_reg.w_data[`RTCNT_BIT_MATCH_FLAG];
                  ctrl_wr.source_select    = st_reg.w_data[`RTCNT_BIT_SRC_HI:`RTCNT_BIT_SRC_LO];
                  ctrl_wr.match_irq_enable = st_reg.w_data[`RTCNT_BIT_IRQ_EN];
                  ctrl_wr.divider_select   = st_reg.w_data[`RTCNT_BIT_DIV_HI:`RTCNT_BIT_DIV_LO];
                  if (ctrl_wr.source_select != st_reg.ctrl.source_select)
                     presc_clear = 1'b1;
                  if (ctrl_wr.divider_select != st_reg.ctrl.divider_select)
                     presc_clear = 1'b1;
                  st_next.ctrl = ctrl_wr;
               end
            RTCNT_SEL_COUNT:
               st_next.count = st_reg.count;
            RTCNT_SEL_MODULO:
               if (st_reg.w_lane0)
               begin
                  st_next.modulo = st_reg.w_data;
                  presc_clear    = 1'b1;
               end
            RTCNT_SEL_NONE:
               st_next.bresp = `RTCNT_RESP_SLVERR;
         endcase
      end

      // read channel
      if (s_axil_arvalid && !st_reg.rvalid)
      begin
         st_next.rvalid = 1'b1;
         st_next.rresp  = `RTCNT_RESP_OKAY;
         st_next.rdata  = 32'h0000_0000;
         unique case (ar_sel)
            RTCNT_SEL_STATUS:
               st_next.rdata[7:0] = {st_reg.match_flag, st_reg.ctrl};
            RTCNT_SEL_COUNT:
               st_next.rdata[7:0] = st_reg.count;
            RTCNT_SEL_MODULO:
               st_next.rdata[7:0] = st_reg.modulo;
            RTCNT_SEL_NONE:
               st_next.rresp = `RTCNT_RESP_SLVERR;
         endcase
      end
      else if (st_reg.rvalid && s_axil_rready)
         st_next.rvalid = 1'b0;

      // counter and comparator; a prescaler clear beats a pending tick, a match beats a flag clear
      if (flag_clear)
         st_next.match_flag = 1'b0;
      if (presc_clear)
         st_next.count = `RTCNT_RST_COUNT;
      else if (presc_tick)
      begin
         if (st_reg.count == st_reg.modulo)
         begin
            st_next.count      = `RTCNT_RST_COUNT;
            st_next.match_flag = 1'b1;
         end
         else
            st_next.count = st_reg.count + 8'h01;
      end

      // request follows flag and enable; no gating by wait or stop
      st_next.irq = st_next.match_flag & st_next.ctrl.match_irq_enable;
   end

   // ----------------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (!rst_b)
         st_reg <= RESET_STATE;
      else
         st_reg <= st_next;
   end

   // ----------------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------------
   assign s_axil_bvalid = st_reg.bvalid;
   assign s_axil_bresp  = st_reg.bresp;
   assign s_axil_rvalid = st_reg.rvalid;
   assign s_axil_rdata  = st_reg.rdata;
   assign s_axil_rresp  = st_reg.rresp;
   assign match_irq     = st_reg.irq;

endmodule // rtcnt_periodic_counter

// >>> hdl/rtcnt_prescaler.sv
// binary/decimal prescaler counting source edges
module rtcnt_prescaler
   import rtcnt_pkg::*;
(
   input  wire logic       clock,      // system clock
   input  wire logic       rst_b,      // synchronous reset, active low
   input  wire logic       src_edge,   // one pulse per selected source edge
   input  wire logic       bank,       // low bit of source select
   input  wire logic [3:0] div_sel,    // divider select
   input  wire logic       clear,      // clear prescaler count
   input  wire logic       freeze,     // debug halt
   output logic            tick        // one-cycle prescaler output pulse
);

   `include "rtcnt_cfg.svh"

   rtcnt_presc_state_t st_reg;
   rtcnt_presc_state_t st_next;

   // divide ratio for a select pair; zero means off
   function automatic logic [17:0] div_ratio(input logic b, input logic [3:0] s);
      logic [17:0] r;
      r = 18'h00000;
      unique case ({b, s})
         5'h00, 5'h10: r = 18'h00000;
         5'h01: r = 18'h00008;
         5'h02: r = 18'h00020;
         5'h03: r = 18'h00040;
         5'h04: r = 18'h00080;
         5'h05: r = 18'h00100;
         5'h06: r = 18'h00200;
         5'h07: r = 18'h00400;
         5'h08: r = 18'h00001;
         5'h09: r = 18'h00002;
         5'h0a: r = 18'h00004;
         5'h0b: r = 18'h0000a;
         5'h0c: r = 18'h00010;
         5'h0d: r = 18'h00064;
         5'h0e: r = 18'h001f4;
         5'h0f: r = 18'h003e8;
         5'h11: r = 18'h00400;
         5'h12: r = 18'h00800;
         5'h13: r = 18'h01000;
         5'h14: r = 18'h02000;
         5'h15: r = 18'h04000;
         5'h16: r = 18'h08000;
         5'h17: r = 18'h10000;
         5'h18: r = 18'h003e8;
         5'h19: r = 18'h007d0;
         5'h1a: r = 18'h01388;
         5'h1b: r = 18'h02710;
         5'h1c: r = 18'h04e20;
         5'h1d: r = 18'h0c350;
         5'h1e: r = 18'h186a0;
         5'h1f: r = 18'h30d40;
      endcase
      return r;
   endfunction

   logic [17:0] ratio;

   always_comb
   begin
      ratio        = div_ratio(bank, div_sel);
      st_next      = st_reg;
      st_next.tick = 1'b0;
      if (clear)
         st_next.count = `RTCNT_RST_PRESC;
      else if (freeze || ratio == 18'h00000)
         st_next.count = st_reg.count;
      else if (src_edge)
      begin
         if (st_reg.count == ratio - 18'h00001)
         begin
            st_next.count = `RTCNT_RST_PRESC;
            st_next.tick  = 1'b1;
         end
         else
            st_next.count = st_reg.count + 18'h00001;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_b)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign tick = st_reg.tick;

endmodule // rtcnt_prescaler

// >>> hdl/rtcnt_src_sync.sv
// two-flop synchroniser and rising-edge detector for the three clock sources
module rtcnt_src_sync
   import rtcnt_pkg::*;
(
   input  wire logic clock,      // system clock
   input  wire logic rst_b,      // synchronous reset, active low
   input  wire rtcnt_src_t src_in,   // raw source clocks
   output rtcnt_src_t      src_rise  // one-cycle pulse per source rising edge
);

   rtcnt_sync_state_t st_reg;
   rtcnt_sync_state_t st_next;

   // ----------------------------------------------------------------------------
   // synchroniser; only stage2 looks at stage1
   // ----------------------------------------------------------------------------
   always_comb
   begin
      st_next        = st_reg;
      st_next.stage1 = src_in;
      st_next.stage2 = st_reg.stage1;
      st_next.stage3 = st_reg.stage2;
      st_next.rise   = st_reg.stage2 & ~st_reg.stage3;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_b)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign src_rise = st_reg.rise;

endmodule // rtcnt_src_sync

// >>> pkg/rtcnt_cfg.svh
// offsets, field positions, reset values and response codes of the periodic counter
`ifndef RTCNT_CFG_SVH
`define RTCNT_CFG_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define RTCNT_OFS_STATUS_CONTROL 4'h0
`define RTCNT_OFS_COUNT_VALUE    4'h4
`define RTCNT_OFS_MODULO_LIMIT   4'h8

// ----------------------------------------------------------------------------
// status/control field positions
// ----------------------------------------------------------------------------
`define RTCNT_BIT_MATCH_FLAG     7
`define RTCNT_BIT_SRC_HI         6
`define RTCNT_BIT_SRC_LO         5
`define RTCNT_BIT_IRQ_EN         4
`define RTCNT_BIT_DIV_HI         3
`define RTCNT_BIT_DIV_LO         0

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RTCNT_RST_SOURCE         2'h0
`define RTCNT_RST_DIVIDER        4'h0
`define RTCNT_RST_MODULO         8'h00
`define RTCNT_RST_COUNT          8'h00
`define RTCNT_RST_PRESC          18'h00000

// ----------------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------------
`define RTCNT_RESP_OKAY          2'h0
`define RTCNT_RESP_SLVERR        2'h2

`endif

// >>> pkg/rtcnt_pkg.sv
// types shared by the periodic counter modules
package rtcnt_pkg;

   // register selected by a bus address
   typedef enum logic [1:0] {
      RTCNT_SEL_STATUS,
      RTCNT_SEL_COUNT,
      RTCNT_SEL_MODULO,
      RTCNT_SEL_NONE
   } rtcnt_sel_t;

   // software-visible control fields
   typedef struct packed {
      logic [1:0] source_select;
      logic       match_irq_enable;
      logic [3:0] divider_select;
   } rtcnt_ctrl_t;

   // three sampled clock sources: internal, external, low power
   typedef struct packed {
      logic internal_32khz_clock;
      logic external_ref_clock;
      logic low_power_1khz_osc;
   } rtcnt_src_t;

   typedef struct packed {
      rtcnt_src_t stage1;
      rtcnt_src_t stage2;
      rtcnt_src_t stage3;
      rtcnt_src_t rise;
   } rtcnt_sync_state_t;

   typedef struct packed {
      logic [17:0] count;
      logic        tick;
   } rtcnt_presc_state_t;

   typedef struct packed {
      logic        aw_held;
      rtcnt_sel_t  aw_sel;
      logic        w_held;
      logic [7:0]  w_data;
      logic        w_lane0;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        match_flag;
      rtcnt_ctrl_t ctrl;
      logic [7:0]  modulo;
      logic [7:0]  count;
      logic        irq;
   } rtcnt_core_state_t;

endpackage

// >>> test/rtcnt_periodic_counter_bench.sv
// self-checking bench for the periodic real-time counter
`include "rtcnt_cfg.svh"
module rtcnt_periodic_counter_bench
   import rtcnt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // stimulus, model and checks
   // ----------------------------------------
   logic        clock = 1'b0, rst_b = 1'b0;
   logic [3:0]  s_axil_awaddr = 4'h0, s_axil_araddr = 4'h0, s_axil_wstrb = 4'h1;
   logic [31:0] s_axil_wdata = 32'h0;
   logic        s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
   logic        s_axil_arvalid = 1'b0, s_axil_rready = 1'b0, deep_stop = 1'b0, debug_active = 1'b0;
   logic [2:0]  src = 3'h0;
   logic        s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid, match_irq;
   logic [1:0]  s_axil_bresp, s_axil_rresp;
   logic [31:0] s_axil_rdata;
   int          errors = 0, num_checks = 0, seed = 32'h93befc66;
   int          ratio [32] = '{0, 8, 32, 64, 128, 256, 512, 1024, 1, 2, 4, 10, 16, 100, 500, 1000, 0, 1024, 2048,
                               4096, 8192, 16384, 32768, 65536, 1000, 2000, 5000, 10000, 20000, 50000, 100000, 200000};

   rtcnt_periodic_counter #(.ADDR_W(4)) i_rtcnt_periodic_counter (
      .clock, .rst_b, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready, .s_axil_wdata, .s_axil_wstrb,
      .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr,
      .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready,
      .low_power_1khz_osc(src[0]), .external_ref_clock(src[1]), .internal_32khz_clock(src[2]),
      .deep_stop, .debug_active, .match_irq);

   always #10 clock = ~clock;

   task automatic conclude();
      if (errors == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      bit done;
      @(posedge clock);
      done = 1'b0;
      s_axil_awaddr <= a;
      s_axil_wdata <= {24'h000000, v};
      s_axil_awvalid <= 1'b1;
      s_axil_wvalid <= 1'b1;
      s_axil_bready <= 1'($random(seed));
      while (!done)
      begin
         @(posedge clock);
         s_axil_awvalid <= s_axil_awvalid && !s_axil_awready;
         s_axil_wvalid <= s_axil_wvalid && !s_axil_wready;
         done = s_axil_bvalid && s_axil_bready;
         s_axil_bready <= !done;
      end
      chk("bresp", {30'h0, s_axil_bresp}, 32'h0);
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      bit done;
      @(posedge clock);
      done = 1'b0;
      s_axil_araddr <= a;
      s_axil_arvalid <= 1'b1;
      s_axil_rready <= 1'($random(seed));
      while (!done)
      begin
         @(posedge clock);
         s_axil_arvalid <= s_axil_arvalid && !s_axil_arready;
         done = s_axil_rvalid && s_axil_rready;
         s_axil_rready <= !done;
      end
      d = s_axil_rdata;
   endtask

   // n rising edges on one source pin, period of six clocks
   task automatic pulses(input int b, input int n);
      repeat (n)
      begin
         repeat (3) @(posedge clock);
         src[b] <= 1'b1;
         repeat (3) @(posedge clock);
         src[b] <= 1'b0;
      end
      repeat (8) @(posedge clock);
   endtask

   task automatic state(input int cnt, input logic [7:0] st);
      logic [31:0] d;
      rd(`RTCNT_OFS_COUNT_VALUE, d);
      chk("count", d, 32'(cnt));
      rd(`RTCNT_OFS_STATUS_CONTROL, d);
      chk("status", d, {24'h0, st});
      chk("irq", {31'h0, match_irq}, {31'h0, st[7] & st[4]});
   endtask

   task automatic run(input logic [1:0] s, input logic [3:0] dv, input int k, input int m);
      int t;
      t = (ratio[{s[0], dv}] == 0) ? 0 : k;
      wr(`RTCNT_OFS_STATUS_CONTROL, {1'b1, s, 1'b1, dv});
      wr(`RTCNT_OFS_MODULO_LIMIT, 8'(m));
      pulses(s[1] ? 2 : int'(s[0]), k * ((t == 0) ? 5 : ratio[{s[0], dv}]));
      state(t % (m + 1), {t > m, s, 1'b1, dv});
      wr(`RTCNT_OFS_STATUS_CONTROL, {1'b0, s, 1'b0, dv});
      wr(`RTCNT_OFS_COUNT_VALUE, 8'hff);
      state(t % (m + 1), {t > m, s, 1'b0, dv});
      wr(`RTCNT_OFS_STATUS_CONTROL, {1'b1, s, 1'b1, dv ^ 4'h1});
      state(0, {1'b0, s, 1'b1, dv ^ 4'h1});
   endtask

   initial
   begin
      repeat (70000) @(posedge clock);
      errors++;
      conclude();
   end

   initial
   begin
      logic [31:0] d;
      int k;
      repeat (20) @(posedge clock);
      rst_b <= 1'b1;
      state(0, 8'h00);
      rd(`RTCNT_OFS_MODULO_LIMIT, d);
      chk("modulo", d, 32'h0);
      rd(4'hc, d);
      chk("unmapped", {d[29:0], s_axil_rresp}, 32'h2);
      for (int i = 0; i < 16; i++)
      begin
         k = ($random(seed) & 3) + 1;
         run({i[0], 1'b0}, 4'(i), (ratio[i] > 64) ? 1 : k, $random(seed) & 3);
      end
      run(2'b01, 4'h8, 1, 0);
      run(2'b11, 4'h1, 1, 1);
      wr(`RTCNT_OFS_STATUS_CONTROL, 8'h08);
      wr(`RTCNT_OFS_MODULO_LIMIT, 8'hc8);
      debug_active <= 1'b1;
      pulses(0, 3);
      debug_active <= 1'b0;
      pulses(0, 3);
      state(3, 8'h08);
      deep_stop <= 1'b1;
      pulses(0, 2);
      state(5, 8'h08);
      wr(`RTCNT_OFS_MODULO_LIMIT, 8'hc8);
      state(0, 8'h08);
      pulses(0, 2);
      wr(`RTCNT_OFS_STATUS_CONTROL, 8'h28);
      state(0, 8'h28);
      pulses(1, 2);
      state(0, 8'h28);
      deep_stop <= 1'b0;
      pulses(1, 998);
      state(0, 8'h28);
      pulses(1, 2);
      state(1, 8'h28);
      conclude();
   end
endmodule // rtcnt_periodic_counter_bench

// >>> test/rtcnt_periodic_counter_properties.sv
// assertions on the periodic counter ports
module rtcnt_periodic_counter_properties
   import rtcnt_pkg::*;
(
   input wire logic        clock,          // clock
   input wire logic        rst_b,          // reset
   input wire logic        s_axil_awvalid, // aw valid
   input wire logic        s_axil_awready, // aw ready
   input wire logic        s_axil_wvalid,  // w valid
   input wire logic        s_axil_wready,  // w ready
   input wire logic [1:0]  s_axil_bresp,   // b resp
   input wire logic        s_axil_bvalid,  // b valid
   input wire logic        s_axil_bready,  // b ready
   input wire logic        s_axil_arvalid, // ar valid
   input wire logic        s_axil_arready, // ar ready
   input wire logic [31:0] s_axil_rdata,   // r data
   input wire logic        s_axil_rvalid,  // r valid
   input wire logic        s_axil_rready,  // r ready
   input wire logic        debug_active,   // debug halt
   input wire logic        match_irq       // request
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // port checks
   // ----------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   sequence wr_taken;
      s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
   endsequence
   a_reset_idle:
      assert property (disable iff (1'b0) !rst_b |=> !match_irq && !s_axil_bvalid && !s_axil_rvalid)
      else $error("outputs busy after reset");
   a_write_answer:
      assert property (wr_taken |-> ##[1:2] s_axil_bvalid)
      else $error("write not answered");
   a_bresp_hold:
      assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp))
      else $error("write answer dropped");
   a_read_answer:
      assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
      else $error("read not answered");
   a_rdata_hold:
      assert property (s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata))
      else $error("read answer dropped");
   a_rdata_width:
      assert property (s_axil_rvalid |-> s_axil_rdata[31:8] == 24'h000000)
      else $error("read data upper bits set");
   a_irq_drop:
      assert property ($fell(match_irq) && $past(rst_b) |-> s_axil_bvalid)
      else $error("request dropped without write");
   a_debug_freeze:
      assert property ($rose(match_irq) && !s_axil_bvalid |-> !($past(debug_active, 2) && $past(debug_active, 3)))
      else $error("match during debug halt");
endmodule // rtcnt_periodic_counter_properties

bind rtcnt_periodic_counter rtcnt_periodic_counter_properties i_rtcnt_periodic_counter_properties (
   .clock, .rst_b, .s_axil_awvalid, .s_axil_awready, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp,
   .s_axil_bvalid, .s_axil_bready, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rvalid,
   .s_axil_rready, .debug_active, .match_irq);
